// [inc/txd_map.svh]
`ifndef TXD_MAP_SVH
`define TXD_MAP_SVH

// descriptor layout, bit positions within the 128-bit descriptor
`define TXD_DESC_W 128
`define TXD_LEN_LSB 64
`define TXD_LEN_W 20
`define TXD_TYPE_LSB 84
`define TXD_TYPE_W 4
`define TXD_CMD_LSB 88
`define TXD_STA_LSB 96
`define TXD_STA_W 4
`define TXD_OPT_LSB 104
`define TXD_TAG_LSB 112
`define TXD_TAG_W 16

// command field bits
`define TXD_CMD_EOP 0
`define TXD_CMD_FCS 1
`define TXD_CMD_SEG 2
`define TXD_CMD_RS 3
`define TXD_CMD_EXT 5
`define TXD_CMD_TAG 6

// status and packet option bits
`define TXD_STA_DONE 0
`define TXD_OPT_IP 0
`define TXD_OPT_L4 1

// special field layout
`define TXD_TAG_VID_LSB 0
`define TXD_TAG_VID_W 12
`define TXD_TAG_CFI 12
`define TXD_TAG_PRI_LSB 13
`define TXD_TAG_PRI_W 3

// register map, byte addresses
`define TXD_ADDR_W 8
`define TXD_OFS_CTRL 8'h00
`define TXD_OFS_TAG_TYPE 8'h04
`define TXD_OFS_ABORT_CNT 8'h08
`define TXD_OFS_INT_STATUS 8'h0c
`define TXD_OFS_INT_MASK 8'h10

// register fields and reset values
`define TXD_CTRL_TAG_MODE 0
`define TXD_TAG_TYPE_RST 16'h0000
`define TXD_INT_W 3
`define TXD_INT_WB 0
`define TXD_INT_ABORT 1
`define TXD_INT_PKT 2
`define TXD_INT_MASK_RST 3'h0

// bus responses
`define TXD_RESP_OKAY 2'h0
`define TXD_RESP_SLVERR 2'h2

`endif

// [inc/txd_pkg.sv]
`include "txd_map.svh"

package txd_pkg;

   typedef struct packed {
      logic [`TXD_LEN_W-1:0] buffer_length_field;
      logic [`TXD_TYPE_W-1:0] descriptor_type_code;
      logic end_of_packet_bit;
      logic fcs_insert_bit;
      logic segmentation_enable_bit;
      logic report_status_bit;
      logic extended_format_bit;
      logic tag_enable_bit;
      logic ip_checksum_insert_bit;
      logic l4_checksum_insert_bit;
      logic [`TXD_TAG_W-1:0] special_field;
   } txd_desc_type;

   typedef struct packed {
      logic segmentation;
      logic fcs_insert;
      logic tag_insert;
      logic [15:0] tag_type;
      logic [`TXD_TAG_PRI_W-1:0] user_priority_field;
      logic cfi;
      logic [`TXD_TAG_VID_W-1:0] vid;
      logic ip_checksum_insert_bit;
      logic l4_checksum_insert_bit;
      logic aborted;
   } txd_pkt_type;

   typedef struct packed {
      logic [15:0] index;
      logic [`TXD_STA_W-1:0] writeback_status_field;
   } txd_wb_type;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_STORE = 3'b010,
      ST_WB = 3'b100
   } txd_state_type;

endpackage

// [core/txd_field_split.sv]
`timescale 1ns/100ps
`include "txd_map.svh"

module txd_field_split (
   // raw descriptor
   input wire logic [`TXD_DESC_W-1:0] word,
   // decoded fields
   output txd_pkg::txd_desc_type desc
);
   import txd_pkg::*;

   logic [7:0] cmd;
   logic [7:0] opt;

   assign cmd = word[`TXD_CMD_LSB +: 8];
   assign opt = word[`TXD_OPT_LSB +: 8];

   assign desc.buffer_length_field = word[`TXD_LEN_LSB +: `TXD_LEN_W];
   assign desc.descriptor_type_code = word[`TXD_TYPE_LSB +: `TXD_TYPE_W];
   assign desc.end_of_packet_bit = cmd[`TXD_CMD_EOP];
   assign desc.fcs_insert_bit = cmd[`TXD_CMD_FCS];
   assign desc.segmentation_enable_bit = cmd[`TXD_CMD_SEG];
   assign desc.report_status_bit = cmd[`TXD_CMD_RS];
   assign desc.extended_format_bit = cmd[`TXD_CMD_EXT];
   assign desc.tag_enable_bit = cmd[`TXD_CMD_TAG];
   // reserved option bits 7:2 and command bits 4 and 7 are not looked at
   assign desc.ip_checksum_insert_bit = opt[`TXD_OPT_IP];
   assign desc.l4_checksum_insert_bit = opt[`TXD_OPT_L4];
   assign desc.special_field = word[`TXD_TAG_LSB +: `TXD_TAG_W];

endmodule // txd_field_split

// [core/txd_seg_track.sv]
`timescale 1ns/100ps

module txd_seg_track #(
   parameter int LEN_W = 20
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // descriptor taken
   input wire logic take,
   input wire logic first,
   input wire logic eop,
   input wire logic [LEN_W-1:0] total,
   input wire logic [LEN_W-1:0] length,
   // final length disagrees with remaining payload
   output logic mismatch
);

   logic [LEN_W-1:0] remain;
   logic [LEN_W-1:0] next_remain;
   logic [LEN_W-1:0] base;

   always_comb begin
      base = first ? total : remain;
      mismatch = take && eop && (length != base);
      next_remain = remain;
      if (take) begin
         next_remain = eop ? '0 : base - length;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         remain <= '0;
      end else begin
         remain <= next_remain;
      end
   end

endmodule // txd_seg_track

// [core/txd_decode.sv]
// The placing of the registers and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/100ps
`include "txd_map.svh"

// Behaviour
// - report status after buffer stored internally
// - segmentation bit selects segmentation context
// - fcs insert taken only from valid descriptor
// - end of packet marks final buffer
// - final length mismatch aborts, counts abnormal end
// - tag fields from first or eop descriptor
// - write back only with report status, done set
// - four status bits, only done meaningful
// - packet options only from first descriptor
// - l4 checksum insert option overwrites field
// - ip checksum insert option overwrites field
// - global mode plus enable adds tag header
// - special field ignored without tag enable
// - tag holds priority, cfi, 12-bit identifier
// - tagged packet also gets fcs appended
module txd_decode (
   // clock and reset
   input wire logic CORE_CLK,
   input wire logic SYS_RST,
   // axi4-lite register slave
   input wire logic [`TXD_ADDR_W-1:0] S_AXI_AWADDR,
   input wire logic S_AXI_AWVALID,
   output logic S_AXI_AWREADY,
   input wire logic [31:0] S_AXI_WDATA,
   input wire logic [3:0] S_AXI_WSTRB,
   input wire logic S_AXI_WVALID,
   output logic S_AXI_WREADY,
   output logic [1:0] S_AXI_BRESP,
   output logic S_AXI_BVALID,
   input wire logic S_AXI_BREADY,
   input wire logic [`TXD_ADDR_W-1:0] S_AXI_ARADDR,
   input wire logic S_AXI_ARVALID,
   output logic S_AXI_ARREADY,
   output logic [31:0] S_AXI_RDATA,
   output logic [1:0] S_AXI_RRESP,
   output logic S_AXI_RVALID,
   input wire logic S_AXI_RREADY,
   // fetched descriptors
   input wire logic DESC_VALID,
   output logic DESC_READY,
   input wire logic [`TXD_DESC_W-1:0] DESC_WORD,
   input wire logic [15:0] DESC_INDEX,
   input wire logic [`TXD_LEN_W-1:0] SEG_PAYLOAD_LEN,
   input wire logic BUF_STORED,
   // status write-back
   output logic WB_VALID,
   input wire logic WB_READY,
   output txd_pkg::txd_wb_type WB_OUT,
   // per-packet decisions
   output logic PKT_VALID,
   output txd_pkg::txd_pkt_type PKT_OUT,
   // interrupt
   output logic IRQ
);
   import txd_pkg::*;

   txd_state_type state, next_state;
   txd_desc_type desc, cur, next_cur;
   logic [15:0] cur_index, next_cur_index;
   logic in_packet, next_in_packet;
   logic pkt_seg, next_pkt_seg;
   logic pkt_ip, next_pkt_ip;
   logic pkt_l4, next_pkt_l4;
   logic pkt_vle, next_pkt_vle;
   logic pkt_fcs, next_pkt_fcs;
   logic pkt_abort, next_pkt_abort;
   logic [`TXD_TAG_W-1:0] pkt_tag, next_pkt_tag;
   txd_pkt_type pkt_out, next_pkt_out;
   logic pkt_valid, next_pkt_valid;
   logic accept, first, seg_mismatch, stored, tag_on, pkt_seg_now;

   logic aw_held, next_aw_held, w_held, next_w_held;
   logic [`TXD_ADDR_W-1:0] aw_addr, next_aw_addr, wr_addr;
   logic [31:0] w_data, next_w_data, wr_data;
   logic [3:0] w_strb, next_w_strb, wr_strb;
   logic bvalid, next_bvalid, rvalid, next_rvalid, wr_go, rd_go;
   logic [1:0] bresp, next_bresp, rresp, next_rresp;
   logic [31:0] rdata, next_rdata;

   logic global_tag_mode_bit, next_global_tag_mode_bit;
   logic [15:0] tag_type_register, next_tag_type_register;
   logic [31:0] segmentation_abort_counter, next_segmentation_abort_counter;
   logic [`TXD_INT_W-1:0] int_status, next_int_status, int_mask, next_int_mask;
   logic [`TXD_INT_W-1:0] int_set, int_clr;
   logic [31:0] wr_old, wr_new;

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] val,
                                         input logic [3:0] strb);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            res[8*i +: 8] = val[8*i +: 8];
         end
      end
      return res;
   endfunction

   function automatic logic mapped(input logic [`TXD_ADDR_W-1:0] a);
      return a == `TXD_OFS_CTRL || a == `TXD_OFS_TAG_TYPE || a == `TXD_OFS_ABORT_CNT ||
             a == `TXD_OFS_INT_STATUS || a == `TXD_OFS_INT_MASK;
   endfunction

   txd_field_split u_split (
      .word(DESC_WORD),
      .desc(desc)
   );

   txd_seg_track #(.LEN_W(`TXD_LEN_W)) u_seg (
      .clk(CORE_CLK),
      .rst(SYS_RST),
      .take(accept && desc.segmentation_enable_bit),
      .first(first),
      .eop(desc.end_of_packet_bit),
      .total(SEG_PAYLOAD_LEN),
      .length(desc.buffer_length_field),
      .mismatch(seg_mismatch)
   );

   assign DESC_READY = (state == ST_IDLE);
   assign accept = DESC_VALID && DESC_READY;
   assign first = !in_packet;
   assign stored = (state == ST_STORE) && BUF_STORED;
   assign WB_VALID = (state == ST_WB);
   assign WB_OUT.index = cur_index;
   assign WB_OUT.writeback_status_field = `TXD_STA_W'(1) << `TXD_STA_DONE;
   assign PKT_VALID = pkt_valid;
   assign PKT_OUT = pkt_out;
   assign IRQ = |(int_status & int_mask);

   // descriptor engine
   always_comb begin
      next_state = state;
      next_cur = cur;
      next_cur_index = cur_index;
      next_in_packet = in_packet;
      next_pkt_seg = pkt_seg;
      next_pkt_ip = pkt_ip;
      next_pkt_l4 = pkt_l4;
      next_pkt_vle = pkt_vle;
      next_pkt_fcs = pkt_fcs;
      next_pkt_abort = pkt_abort;
      next_pkt_tag = pkt_tag;
      next_pkt_out = pkt_out;
      next_pkt_valid = 1'b0;
      pkt_seg_now = first ? desc.segmentation_enable_bit : pkt_seg;
      tag_on = global_tag_mode_bit && pkt_vle;
      case (state)
         ST_IDLE: begin
            if (accept) begin
               next_cur = desc;
               next_cur_index = DESC_INDEX;
               next_state = ST_STORE;
               next_in_packet = !desc.end_of_packet_bit;
               if (first) begin
                  next_pkt_seg = desc.segmentation_enable_bit;
                  next_pkt_ip = desc.ip_checksum_insert_bit;
                  next_pkt_l4 = desc.l4_checksum_insert_bit;
                  next_pkt_abort = 1'b0;
               end
               // tag and fcs fields live in one descriptor only
               if ((first && pkt_seg_now) || (desc.end_of_packet_bit && !pkt_seg_now)) begin
                  next_pkt_vle = desc.tag_enable_bit;
                  next_pkt_fcs = desc.fcs_insert_bit;
                  next_pkt_tag = desc.special_field;
               end
               if (seg_mismatch) begin
                  next_pkt_abort = 1'b1;
               end
            end
         end
         ST_STORE: begin
            if (BUF_STORED) begin
               next_state = cur.report_status_bit ? ST_WB : ST_IDLE;
               if (cur.end_of_packet_bit) begin
                  next_pkt_valid = 1'b1;
                  next_pkt_out.segmentation = pkt_seg;
                  next_pkt_out.tag_insert = tag_on;
                  next_pkt_out.fcs_insert = tag_on || pkt_fcs;
                  next_pkt_out.tag_type = tag_type_register;
                  // special field is dropped unless a tag goes out
                  next_pkt_out.user_priority_field =
                     tag_on ? pkt_tag[`TXD_TAG_PRI_LSB +: `TXD_TAG_PRI_W] : '0;
                  next_pkt_out.cfi = tag_on && pkt_tag[`TXD_TAG_CFI];
                  next_pkt_out.vid =
                     tag_on ? pkt_tag[`TXD_TAG_VID_LSB +: `TXD_TAG_VID_W] : '0;
                  next_pkt_out.ip_checksum_insert_bit = pkt_ip;
                  next_pkt_out.l4_checksum_insert_bit = pkt_l4;
                  next_pkt_out.aborted = pkt_abort;
               end
            end
         end
         ST_WB: begin
            if (WB_READY) begin
               next_state = ST_IDLE;
            end
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         state <= ST_IDLE;
         cur <= '0;
         cur_index <= '0;
         in_packet <= 1'b0;
         pkt_seg <= 1'b0;
         pkt_ip <= 1'b0;
         pkt_l4 <= 1'b0;
         pkt_vle <= 1'b0;
         pkt_fcs <= 1'b0;
         pkt_abort <= 1'b0;
         pkt_tag <= '0;
         pkt_out <= '0;
         pkt_valid <= 1'b0;
      end else begin
         state <= next_state;
         cur <= next_cur;
         cur_index <= next_cur_index;
         in_packet <= next_in_packet;
         pkt_seg <= next_pkt_seg;
         pkt_ip <= next_pkt_ip;
         pkt_l4 <= next_pkt_l4;
         pkt_vle <= next_pkt_vle;
         pkt_fcs <= next_pkt_fcs;
         pkt_abort <= next_pkt_abort;
         pkt_tag <= next_pkt_tag;
         pkt_out <= next_pkt_out;
         pkt_valid <= next_pkt_valid;
      end
   end

   // bus channels; a write may complete in the cycle its last half arrives
   assign S_AXI_AWREADY = !aw_held && !bvalid;
   assign S_AXI_WREADY = !w_held && !bvalid;
   assign S_AXI_ARREADY = !rvalid;
   assign S_AXI_BVALID = bvalid;
   assign S_AXI_BRESP = bresp;
   assign S_AXI_RVALID = rvalid;
   assign S_AXI_RDATA = rdata;
   assign S_AXI_RRESP = rresp;
   assign wr_addr = aw_held ? aw_addr : S_AXI_AWADDR;
   assign wr_data = w_held ? w_data : S_AXI_WDATA;
   assign wr_strb = w_held ? w_strb : S_AXI_WSTRB;
   assign wr_go = (aw_held || S_AXI_AWVALID) && (w_held || S_AXI_WVALID) && !bvalid;
   assign rd_go = S_AXI_ARVALID && S_AXI_ARREADY;

   always_comb begin
      next_aw_held = aw_held;
      next_aw_addr = aw_addr;
      next_w_held = w_held;
      next_w_data = w_data;
      next_w_strb = w_strb;
      next_bvalid = bvalid;
      next_bresp = bresp;
      next_rvalid = rvalid;
      next_rresp = rresp;
      next_rdata = rdata;
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
         next_aw_held = 1'b1;
         next_aw_addr = S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
         next_w_held = 1'b1;
         next_w_data = S_AXI_WDATA;
         next_w_strb = S_AXI_WSTRB;
      end
      if (wr_go) begin
         next_aw_held = 1'b0;
         next_w_held = 1'b0;
         next_bvalid = 1'b1;
         next_bresp = mapped(wr_addr) ? `TXD_RESP_OKAY : `TXD_RESP_SLVERR;
      end else if (bvalid && S_AXI_BREADY) begin
         next_bvalid = 1'b0;
      end
      if (rd_go) begin
         next_rvalid = 1'b1;
         next_rresp = mapped(S_AXI_ARADDR) ? `TXD_RESP_OKAY : `TXD_RESP_SLVERR;
         case (S_AXI_ARADDR)
            `TXD_OFS_CTRL: next_rdata = 32'(global_tag_mode_bit) << `TXD_CTRL_TAG_MODE;
            `TXD_OFS_TAG_TYPE: next_rdata = {16'h0000, tag_type_register};
            `TXD_OFS_ABORT_CNT: next_rdata = segmentation_abort_counter;
            `TXD_OFS_INT_STATUS: next_rdata = 32'(int_status);
            `TXD_OFS_INT_MASK: next_rdata = 32'(int_mask);
            default: next_rdata = 32'h0000_0000;
         endcase
      end else if (rvalid && S_AXI_RREADY) begin
         next_rvalid = 1'b0;
      end
   end

   always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         aw_held <= 1'b0;
         aw_addr <= '0;
         w_held <= 1'b0;
         w_data <= '0;
         w_strb <= '0;
         bvalid <= 1'b0;
         bresp <= `TXD_RESP_OKAY;
         rvalid <= 1'b0;
         rresp <= `TXD_RESP_OKAY;
         rdata <= '0;
      end else begin
         aw_held <= next_aw_held;
         aw_addr <= next_aw_addr;
         w_held <= next_w_held;
         w_data <= next_w_data;
         w_strb <= next_w_strb;
         bvalid <= next_bvalid;
         bresp <= next_bresp;
         rvalid <= next_rvalid;
         rresp <= next_rresp;
         rdata <= next_rdata;
      end
   end

   // registers and interrupt status; a new event beats a read-clear
   always_comb begin
      next_global_tag_mode_bit = global_tag_mode_bit;
      next_tag_type_register = tag_type_register;
      next_int_mask = int_mask;
      next_segmentation_abort_counter = segmentation_abort_counter;
      int_set = '0;
      int_set[`TXD_INT_WB] = WB_VALID && WB_READY;
      int_set[`TXD_INT_ABORT] = accept && seg_mismatch;
      int_set[`TXD_INT_PKT] = stored && cur.end_of_packet_bit;
      int_clr = (rd_go && S_AXI_ARADDR == `TXD_OFS_INT_STATUS) ? '1 : '0;
      next_int_status = (int_status & ~int_clr) | int_set;
      if (accept && seg_mismatch) begin
         next_segmentation_abort_counter = segmentation_abort_counter + 32'h0000_0001;
      end
      // merged word held apart, since a call result cannot be bit-selected
      case (wr_addr)
         `TXD_OFS_CTRL: wr_old = 32'(global_tag_mode_bit) << `TXD_CTRL_TAG_MODE;
         `TXD_OFS_TAG_TYPE: wr_old = {16'h0000, tag_type_register};
         `TXD_OFS_INT_MASK: wr_old = 32'(int_mask);
         default: wr_old = 32'h0000_0000;
      endcase
      wr_new = merge(wr_old, wr_data, wr_strb);
      if (wr_go) begin
         case (wr_addr)
            `TXD_OFS_CTRL: next_global_tag_mode_bit = wr_new[`TXD_CTRL_TAG_MODE];
            `TXD_OFS_TAG_TYPE: next_tag_type_register = wr_new[15:0];
            `TXD_OFS_INT_MASK: next_int_mask = wr_new[`TXD_INT_W-1:0];
            default: next_int_mask = int_mask;
         endcase
      end
   end

   always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         global_tag_mode_bit <= 1'b0;
         tag_type_register <= `TXD_TAG_TYPE_RST;
         segmentation_abort_counter <= '0;
         int_status <= '0;
         int_mask <= `TXD_INT_MASK_RST;
      end else begin
         global_tag_mode_bit <= next_global_tag_mode_bit;
         tag_type_register <= next_tag_type_register;
         segmentation_abort_counter <= next_segmentation_abort_counter;
         int_status <= next_int_status;
         int_mask <= next_int_mask;
      end
   end

   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (SYS_RST);

   a_wb_needs_rs: assert property ($rose(WB_VALID) |-> cur.report_status_bit)
      else $error("write-back without report status");
   a_wb_after_store: assert property ($rose(WB_VALID) |-> $past(stored))
      else $error("write-back before buffer stored");
   a_wb_rs_follows: assert property (stored && cur.report_status_bit |=> WB_VALID)
      else $error("report status did not raise write-back");
   a_wb_status_bits: assert property (WB_VALID |-> WB_OUT.writeback_status_field == 4'h1)
      else $error("write-back status not done-only");
   a_pkt_on_eop: assert property (PKT_VALID |-> $past(stored && cur.end_of_packet_bit))
      else $error("packet decision without final buffer");
   a_seg_from_first: assert property (accept && first |=>
      pkt_seg == $past(desc.segmentation_enable_bit))
      else $error("segmentation context not from first descriptor");
   a_opts_held: assert property (accept && !first |=>
      $stable(pkt_ip) && $stable(pkt_l4))
      else $error("packet options changed after first descriptor");
   a_opts_taken: assert property (accept && first |=>
      pkt_ip == $past(desc.ip_checksum_insert_bit) &&
      pkt_l4 == $past(desc.l4_checksum_insert_bit))
      else $error("checksum options not latched");
   a_tag_source: assert property (accept && !first && pkt_seg |=>
      $stable(pkt_tag) && $stable(pkt_vle) && $stable(pkt_fcs))
      else $error("tag fields taken from later segmentation descriptor");
   a_tag_fcs: assert property (PKT_VALID && PKT_OUT.tag_insert |->
      PKT_OUT.fcs_insert && $past(global_tag_mode_bit))
      else $error("tagged packet without fcs or global mode");
   a_tag_ignored: assert property (PKT_VALID && !PKT_OUT.tag_insert |->
      PKT_OUT.vid == 12'h000 && !PKT_OUT.cfi && PKT_OUT.user_priority_field == 3'h0)
      else $error("special field leaked without tag");
   a_abort_count: assert property (accept && seg_mismatch |=>
      segmentation_abort_counter == $past(segmentation_abort_counter) + 32'h0000_0001)
      else $error("abort counter not advanced");

endmodule // txd_decode

// [verif/txd_host_model.sv]
`timescale 1ns/100ps

module txd_host_model (
   // clock
   input wire logic clk,
   // descriptor offer
   output logic desc_valid,
   input wire logic desc_ready,
   output logic [127:0] desc_word,
   output logic [15:0] desc_index,
   output logic buf_stored,
   // write-back acceptance
   output logic wb_ready
);
   logic [7:0] pace = 8'h5b;

   initial begin
      desc_valid = 1'b0;
      desc_word = '0;
      desc_index = '0;
      buf_stored = 1'b0;
      wb_ready = 1'b0;
   end

   // rotating pattern mixes prompt and slow acceptance of write-backs
   always @(posedge clk) begin
      pace <= {pace[6:0], pace[7]};
      wb_ready <= pace[0] | pace[3];
   end

   // type 0001, extension set, every reserved bit zero, ipv4 traffic only
   function automatic logic [127:0] mk(input logic [19:0] len, input logic eop, fcs, seg, rs,
                                      tag, ip, l4, input logic [15:0] sp);
      return {sp, 6'h0, l4, ip, 8'h0, 1'b0, tag, 1'b1, 1'b0, rs, seg, fcs, eop, 4'h1, len,
              64'h0};
   endfunction

   task automatic send(input logic [127:0] w, input logic [15:0] idx, input logic [2:0] dly);
      desc_valid <= 1'b1;
      desc_word <= w;
      desc_index <= idx;
      do @(posedge clk); while (!desc_ready);
      desc_valid <= 1'b0;
      // released word must not keep showing the old value
      desc_word <= ~w;
      repeat (dly) @(posedge clk);
      buf_stored <= 1'b1;
      @(posedge clk);
      buf_stored <= 1'b0;
   endtask
endmodule // txd_host_model

// [verif/tb_top.sv]
`timescale 1ns/100ps
`include "txd_map.svh"
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin n_errors++; \
   $display("mismatch %s exp %h got %h", nm, e, g); end end

module tb_top;
   import txd_pkg::*;
   logic clk = 0, rst = 1, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0;
   logic [7:0] awa = '0, ara = '0;
   logic [31:0] wd = '0, rd;
   logic [19:0] seg_len = '0;
   logic awr, wr, bv, arr, rv, dv, dr, bs, wbv, wbr, pv, irq;
   logic [1:0] br, rr;
   logic [127:0] dw;
   logic [15:0] di, lf = 16'd806, tt, idx = '0, wq;
   txd_wb_type wbo;
   txd_pkt_type po, ep;
   int n_errors = 0, compares = 0, npk = 0, ab = 0;
   logic [15:0] wbq[$];

   always #4 clk = ~clk;

   txd_decode uut (.CORE_CLK(clk), .SYS_RST(rst), .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv),
      .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wv),
      .S_AXI_WREADY(wr), .S_AXI_BRESP(br), .S_AXI_BVALID(bv), .S_AXI_BREADY(bry),
      .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_RDATA(rd),
      .S_AXI_RRESP(rr), .S_AXI_RVALID(rv), .S_AXI_RREADY(rry), .DESC_VALID(dv),
      .DESC_READY(dr), .DESC_WORD(dw), .DESC_INDEX(di), .SEG_PAYLOAD_LEN(seg_len),
      .BUF_STORED(bs), .WB_VALID(wbv), .WB_READY(wbr), .WB_OUT(wbo), .PKT_VALID(pv),
      .PKT_OUT(po), .IRQ(irq));

   txd_host_model host (.clk(clk), .desc_valid(dv), .desc_ready(dr), .desc_word(dw),
      .desc_index(di), .buf_stored(bs), .wb_ready(wbr));

   function automatic logic [15:0] rnd();
      lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
      return lf;
   endfunction

   task automatic final_report();
      $display("errors %0d compares %0d", n_errors, compares);
      if (n_errors == 0 && compares > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      awa <= a;
      wd <= d;
      awv <= 1'b1;
      wv <= 1'b1;
      bry <= 1'b1;
      do begin @(posedge clk); if (awr) awv <= 1'b0; if (wr) wv <= 1'b0; end while (!bv);
      bry <= 1'b0;
      `CHK("bresp", er, br)
      // one idle edge so the next call never re-raises bready in this step
      @(posedge clk);
   endtask

   task automatic axr(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
      ara <= a;
      arv <= 1'b1;
      rry <= 1'b1;
      do begin @(posedge clk); if (arr) arv <= 1'b0; end while (!rv);
      rry <= 1'b0;
      `CHK("rresp", er, rr)
      `CHK("rdata", e, rd)
      @(posedge clk);
   endtask

   task automatic pkt();
      logic [15:0] r, sp;
      logic [19:0] rem, len;
      logic [2:0] msk, st;
      logic gm, seg, bad, last, anyrs;
      int n;
      r = rnd();
      {gm, msk, seg, bad} = {r[0], r[3:1], r[4], r[5] & r[6]};
      n = 1 + r[9:8] % 3;
      tt = rnd();
      axw(`TXD_OFS_CTRL, {31'h0, gm}, `TXD_RESP_OKAY);
      axw(`TXD_OFS_TAG_TYPE, {16'h0, tt}, `TXD_RESP_OKAY);
      axw(`TXD_OFS_INT_MASK, {29'h0, msk}, `TXD_RESP_OKAY);
      rem = {4'h0, rnd()};
      seg_len <= rem;
      ep = '0;
      ep.segmentation = seg;
      ep.aborted = seg & bad;
      ep.tag_type = tt;
      anyrs = 1'b0;
      for (int i = 0; i < n; i++) begin
         r = rnd();
         sp = rnd();
         last = i == n - 1;
         // a bad final length leaves one byte over the remaining payload
         len = (last && seg) ? rem + 20'(bad) : {12'h0, r[15:8]};
         rem = rem - len;
         if (i == 0)
            {ep.ip_checksum_insert_bit, ep.l4_checksum_insert_bit} = {r[3], r[4]};
         if (seg ? i == 0 : last) begin
            ep.tag_insert = gm & r[1];
            ep.fcs_insert = ep.tag_insert | r[0];
            if (ep.tag_insert)
               {ep.user_priority_field, ep.cfi, ep.vid} = sp;
         end
         if (r[2])
            wbq.push_back(idx);
         anyrs |= r[2];
         host.send(host.mk(len, last, r[0], seg, r[2], r[1], r[3], r[4], sp), idx, r[7:5]);
         idx++;
      end
      do @(posedge clk); while (!dr);
      @(posedge clk);
      st = {1'b1, seg & bad, anyrs};
      `CHK("irq", |(st & msk), irq)
      axr(`TXD_OFS_INT_STATUS, {29'h0, st}, `TXD_RESP_OKAY);
      axr(`TXD_OFS_INT_STATUS, '0, `TXD_RESP_OKAY);
      `CHK("irq_clear", 1'b0, irq)
      ab += seg & bad;
   endtask

   always @(posedge clk) begin
      if (pv) begin
         `CHK("pkt", ep, po)
         npk++;
      end
      if (wbv && wbr) begin
         wq = wbq.pop_front();
         `CHK("wb", {wq, 4'h1}, wbo)
      end
   end

   initial begin
      repeat (30000) @(posedge clk);
      n_errors++;
      final_report();
   end

   initial begin
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      for (int a = 0; a <= 20; a += 4)
         axr(8'(a), '0, a == 20 ? `TXD_RESP_SLVERR : `TXD_RESP_OKAY);
      axw(8'h14, 32'h1, `TXD_RESP_SLVERR);
      axw(`TXD_OFS_ABORT_CNT, 32'h5, `TXD_RESP_OKAY);
      axw(`TXD_OFS_TAG_TYPE, 32'hffff_ffff, `TXD_RESP_OKAY);
      axr(`TXD_OFS_TAG_TYPE, 32'h0000_ffff, `TXD_RESP_OKAY);
      for (int k = 0; k < 40; k++)
         pkt();
      axr(`TXD_OFS_ABORT_CNT, 32'(ab), `TXD_RESP_OKAY);
      `CHK("wb_left", 0, wbq.size())
      `CHK("pkts", 40, npk)
      final_report();
   end
endmodule // tb_top
